/* partition_id_cfg_pkg.sv */
/*
 * package for the partition narrowing and bandwidth maximum register bank:
 * offsets, field positions, sizes, reset values and carrier structs.
 * assumes a simple synchronous word access port, 32-bit data.
 */
package partition_id_cfg_pkg;
	// ----------------------------------------------------------------
	// sizes
	// ----------------------------------------------------------------
	localparam int unsigned partition_id_count = 16;
	localparam int unsigned partition_id_index_width = 4;
	localparam int unsigned ris_count = 2;
	localparam int unsigned ris_index_width = 1;
	localparam int unsigned frame_count = 2;
	// ----------------------------------------------------------------
	// offsets within a feature frame
	// ----------------------------------------------------------------
	localparam logic [15:0] bandwidth_max_limit_offset = 16'h0208;
	localparam logic [15:0] partition_id_narrowing_map_offset = 16'h0600;
	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int unsigned map_internal_bit = 16;
	localparam int unsigned hard_limit_bit = 31;
	localparam int unsigned field_msb = 15;
	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [15:0] narrowed_id_reset = 16'h0000;
	localparam logic [15:0] bw_max_reset = 16'h0000;
	localparam logic internal_flag_reset = 1'h0;
	localparam logic hard_limit_reset = 1'h0;
	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic valid;
		logic write;
		logic secure;
		logic [15:0] offset;
		logic [31:0] wdata;
	} access_type;
	typedef struct packed {
		logic [15:0] partition_id_select_field;
		logic [7:0] resource_instance_selector;
		logic internal_select;
	} partition_select_type;
	typedef struct packed {
		logic valid;
		logic [31:0] rdata;
		logic range_error;
		logic internal_error;
	} answer_type;
endpackage

/* partition_id_cfg_bank.sv */
/*
 * partition_id_cfg_bank: narrowing map and bandwidth maximum registers, with
 * separate secure and non-secure copies. assumes the partition select
 * register, error status register and id values live outside; error
 * outputs are one-cycle pulses for the error status register.
 */
// Notes on behaviour
// - narrowing map read returns the narrowed id of the selected request id.
// - out of range or flag clear write leaves mapping unchanged, range error raised; flag bit still stored.
// - internal select set on map access raises unexpected internal error.
// - map absent unless feature and narrowing present; reads zero then.
// - flag bit 16 must be one; flag zero never updates mapping.
// - flag bit reads back the value last written.
// - map holds narrowed id in bits 15:0; bits 31:17 read zero.
// - narrowed ids above the ceiling are out of range.
// - secure and non-secure maps at 0x0600, each own id space.
// - map accesses ignore the resource instance selector.
// - map indexed by partition id select; internal select kept zero.
// - hard limit bit 31 selects hard or soft limiting mode.
// - maximum in bits 15:0 as fraction below one; 30:16 zero.
// - only top fraction-width bits stored; lower bits read zero.
// - bandwidth maximum absent unless feature and both present bits set.
// - maximum indexed by instance selector and partition when present.
// - maximum indexed by the requested partition id select field; narrowing not applied.
// - secure and non-secure maximum registers at 0x0208.
`timescale 1ns/1ps
module partition_id_cfg_bank #(
	parameter logic [3:0] bandwidth_fraction_width = 4'h8
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire partition_id_cfg_pkg::access_type access,
	input wire partition_id_cfg_pkg::partition_select_type sel_s,
	input wire partition_id_cfg_pkg::partition_select_type sel_ns,
	input wire logic partitioning_feature,
	input wire logic narrowing_present_flag,
	input wire logic bandwidth_partitioning_present,
	input wire logic max_limit_present,
	input wire logic instance_select_present,
	input wire logic [15:0] narrowed_id_ceiling,
	output partition_id_cfg_pkg::answer_type answer,
	output logic [partition_id_cfg_pkg::frame_count*partition_id_cfg_pkg::ris_count
		*partition_id_cfg_pkg::partition_id_count-1:0] hard_limit_flag,
	output logic [partition_id_cfg_pkg::frame_count*partition_id_cfg_pkg::ris_count
		*partition_id_cfg_pkg::partition_id_count*16-1:0] bw_max_limits
);
	localparam int unsigned np = partition_id_cfg_pkg::partition_id_count;
	localparam int unsigned nm = partition_id_cfg_pkg::frame_count * np;
	localparam int unsigned nb = nm * partition_id_cfg_pkg::ris_count;

	typedef struct packed {
		logic [nm-1:0][15:0] narrowed;
		logic [1:0] flag;
		logic [nb-1:0][15:0] bw_max;
		logic [nb-1:0] hard;
		partition_id_cfg_pkg::answer_type answer;
	} state_type;

	state_type state_reg;
	state_type state_next;

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	partition_id_cfg_pkg::partition_select_type sel;
	logic map_present;
	logic bw_present;
	logic map_hit;
	logic bw_hit;
	logic [15:0] keep_mask;
	logic [partition_id_cfg_pkg::partition_id_index_width:0] map_idx;
	logic [partition_id_cfg_pkg::partition_id_index_width+1:0] bw_idx;
	logic ris_bit;
	logic [15:0] map_id;
	logic [15:0] bw_id;

	always_comb begin
		sel = access.secure ? sel_s : sel_ns;
		map_present = partitioning_feature & narrowing_present_flag;
		bw_present = partitioning_feature & bandwidth_partitioning_present
			& max_limit_present;
		map_hit = access.valid & map_present
			& access.offset == partition_id_cfg_pkg::partition_id_narrowing_map_offset;
		bw_hit = access.valid & bw_present
			& access.offset == partition_id_cfg_pkg::bandwidth_max_limit_offset;
		// map index ignores instance selector
		map_id = sel.partition_id_select_field;
		map_idx = {access.secure,
			map_id[partition_id_cfg_pkg::partition_id_index_width-1:0]};
		// narrowed or requested id, same select field either way
		bw_id = sel.partition_id_select_field;
		ris_bit = instance_select_present
			? sel.resource_instance_selector[0] : 1'h0;
		bw_idx = {access.secure, ris_bit,
			bw_id[partition_id_cfg_pkg::partition_id_index_width-1:0]};
	end

	// implemented fraction bits, top down
	for (genvar b = 0; b < 16; b++) begin : g_mask
		assign keep_mask[b] =
			(16 - b) <= int'(bandwidth_fraction_width);
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		state_next.answer = '0;
		state_next.answer.valid = access.valid;
		if (map_hit) begin
			state_next.answer.internal_error = sel.internal_select;
			if (access.write) begin
				state_next.flag[access.secure] =
					access.wdata[partition_id_cfg_pkg::map_internal_bit];
				if (!access.wdata[partition_id_cfg_pkg::map_internal_bit]
					|| access.wdata[15:0] > narrowed_id_ceiling) begin
					state_next.answer.range_error = 1'h1;
				end else if (!sel.internal_select) begin
					state_next.narrowed[map_idx] =
						access.wdata[15:0];
				end
			end else begin
				state_next.answer.rdata = {15'h0000,
					state_reg.flag[access.secure],
					state_reg.narrowed[map_idx]};
			end
		end else if (bw_hit) begin
			if (access.write) begin
				state_next.hard[bw_idx] =
					access.wdata[partition_id_cfg_pkg::hard_limit_bit];
				state_next.bw_max[bw_idx] =
					access.wdata[15:0] & keep_mask;
			end else begin
				state_next.answer.rdata = {state_reg.hard[bw_idx],
					15'h0000, state_reg.bw_max[bw_idx]};
			end
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			state_reg.narrowed <= {nm{partition_id_cfg_pkg::narrowed_id_reset}};
			state_reg.flag <= {2{partition_id_cfg_pkg::internal_flag_reset}};
			state_reg.bw_max <= {nb{partition_id_cfg_pkg::bw_max_reset}};
			state_reg.hard <= {nb{partition_id_cfg_pkg::hard_limit_reset}};
			state_reg.answer <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	always_comb begin
		answer = state_reg.answer;
		hard_limit_flag = state_reg.hard;
		bw_max_limits = state_reg.bw_max;
	end
endmodule

/* partition_id_cfg_bank_asserts.sv */
/* port checker of partition_id_cfg_bank, bound at the foot of this file.
   assumes the top module ports as the design declares them. */
`timescale 1ns/1ps
module partition_id_cfg_bank_asserts #(
	parameter logic [3:0] bandwidth_fraction_width = 4'h8
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire partition_id_cfg_pkg::access_type access,
	input wire partition_id_cfg_pkg::partition_select_type sel_s,
	input wire partition_id_cfg_pkg::partition_select_type sel_ns,
	input wire logic partitioning_feature,
	input wire logic narrowing_present_flag,
	input wire logic [15:0] narrowed_id_ceiling,
	input wire partition_id_cfg_pkg::answer_type answer
);
	logic map_acc, bw_acc, map_on, map_wr, sel_int;
	assign map_acc = access.valid && access.offset == 16'h0600;
	assign bw_acc = access.valid && access.offset == 16'h0208;
	assign map_on = partitioning_feature && narrowing_present_flag;
	assign map_wr = map_acc && map_on && access.write;
	assign sel_int = access.secure ? sel_s.internal_select
		: sel_ns.internal_select;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	// ----
	// assertions
	// ----
	answer_timing_a: assert property (access.valid |=> answer.valid)
		else $error("no answer");
	map_reserved_a: assert property (
		map_acc |=> answer.rdata[31:17] == 15'h0) else $error("map bits");
	bw_reserved_a: assert property (
		bw_acc |=> answer.rdata[30:16] == 15'h0) else $error("max bits");
	bw_low_zero_a: assert property (bw_acc |=>
		(answer.rdata[15:0] & (16'hFFFF >> bandwidth_fraction_width)) == 16'h0)
		else $error("max low bits");
	internal_err_a: assert property (
		map_acc && map_on && sel_int |=> answer.internal_error)
		else $error("internal error missing");
	flag_clear_a: assert property (
		map_wr && !access.wdata[16] |=> answer.range_error)
		else $error("flag error missing");
	range_err_a: assert property (
		map_wr && access.wdata[15:0] > narrowed_id_ceiling |=> answer.range_error)
		else $error("range error missing");
	map_absent_a: assert property (
		map_acc && !map_on |=> answer.rdata == 32'h0) else $error("absent map");
	cover property (map_wr && access.wdata[16]);
	cover property (bw_acc && access.write);
	cover property (map_acc && sel_int);
endmodule
bind partition_id_cfg_bank partition_id_cfg_bank_asserts #(
	.bandwidth_fraction_width(bandwidth_fraction_width)
) chk_i (.clk_sys, .rstn, .access, .sel_s, .sel_ns, .partitioning_feature,
	.narrowing_present_flag, .narrowed_id_ceiling, .answer);

/* tb_partition_id_cfg_bank.sv */
/* self-checking bench of partition_id_cfg_bank through its access port and its hard limit and maximum outputs.
   assumes one-cycle answers and a fraction width of 8. */
`timescale 1ns/1ps
module tb_partition_id_cfg_bank;
	localparam logic [15:0] mo = 16'h0600;
	localparam logic [15:0] bo = 16'h0208;
	logic clk_sys = 1'b0;
	logic rstn = 1'b0;
	logic nrw = 1'b1;
	logic mxp = 1'b1;
	logic isp = 1'b1;
	partition_id_cfg_pkg::access_type access = '0;
	partition_id_cfg_pkg::partition_select_type sel_s = '0;
	partition_id_cfg_pkg::partition_select_type sel_ns = '0;
	partition_id_cfg_pkg::answer_type answer;
	logic [63:0] hl;
	logic [1023:0] lim;
	int n_mismatch = 0;
	int checked = 0;
	partition_id_cfg_bank dut (.clk_sys, .rstn, .access, .sel_s, .sel_ns,
		.partitioning_feature(1'b1), .narrowing_present_flag(nrw),
		.bandwidth_partitioning_present(1'b1), .max_limit_present(mxp),
		.instance_select_present(isp), .narrowed_id_ceiling(16'h000A),
		.answer, .hard_limit_flag(hl), .bw_max_limits(lim));
	always #4 clk_sys = ~clk_sys;
	task automatic complete_run;
		$display("mismatches %0d checks %0d", n_mismatch, checked);
		if (n_mismatch == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] e,
		input logic [31:0] g);
		checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected %s: expected %h seen %h", what, e, g);
		end
	endtask
	task automatic ps(input logic s, input logic [15:0] p,
		input logic [7:0] r, input logic i);
		@(posedge clk_sys);
		if (s)
			sel_s <= '{p, r, i};
		else
			sel_ns <= '{p, r, i};
	endtask
	task automatic acc(input logic s, input logic w, input logic [15:0] o,
		input logic [31:0] d, input logic [31:0] x, input logic [1:0] e);
		@(posedge clk_sys);
		access <= '{1'b1, w, s, o, d};
		@(posedge clk_sys);
		access.valid <= 1'b0;
		#1;
		chk("rdata", x, answer.rdata);
		chk("errors", {30'h0, e}, {30'h0, answer.range_error,
			answer.internal_error});
	endtask
	initial begin
		#20000;
		n_mismatch++;
		complete_run();
	end
	// ----
	// tests
	// ----
	initial begin
		repeat (6) @(posedge clk_sys);
		rstn <= 1'b1;
		ps(0, 3, 0, 0);
		acc(0, 1, mo, 32'h0001000A, 32'h0, 2'h0);
		acc(0, 0, mo, 32'h0, 32'h0001000A, 2'h0);
		ps(1, 3, 0, 0);
		acc(1, 0, mo, 32'h0, 32'h0, 2'h0);
		acc(0, 1, mo, 32'h00000007, 32'h0, 2'h2);
		acc(0, 0, mo, 32'h0, 32'h0000000A, 2'h0);
		acc(0, 1, mo, 32'h0001000B, 32'h0, 2'h2);
		ps(0, 3, 1, 0);
		acc(0, 0, mo, 32'h0, 32'h0001000A, 2'h0);
		ps(0, 3, 0, 1);
		acc(0, 1, mo, 32'h00010002, 32'h0, 2'h1);
		ps(0, 3, 0, 0);
		acc(0, 0, mo, 32'h0, 32'h0001000A, 2'h0);
		nrw <= 1'b0;
		acc(0, 1, mo, 32'h00010001, 32'h0, 2'h0);
		acc(0, 0, mo, 32'h0, 32'h0, 2'h0);
		nrw <= 1'b1;
		acc(0, 0, mo, 32'h0, 32'h0001000A, 2'h0);
		ps(1, 5, 1, 0);
		acc(1, 1, bo, 32'hFFFFFFFF, 32'h0, 2'h0);
		acc(1, 0, bo, 32'h0, 32'h8000FF00, 2'h0);
		chk("limit", {16'h0, 16'hFF00}, {16'h0, lim[53*16+:16]});
		chk("hard", 32'h1, {31'h0, hl[53]});
		ps(0, 5, 0, 0);
		acc(0, 0, bo, 32'h0, 32'h0, 2'h0);
		acc(0, 0, 16'h0100, 32'h0, 32'h0, 2'h0);
		isp <= 1'b0;
		ps(1, 5, 1, 0);
		acc(1, 1, bo, 32'h00001234, 32'h0, 2'h0);
		chk("limit", {16'h0, 16'h1200}, {16'h0, lim[37*16+:16]});
		chk("limit", {16'h0, 16'hFF00}, {16'h0, lim[53*16+:16]});
		mxp <= 1'b0;
		acc(1, 0, bo, 32'h0, 32'h0, 2'h0);
		complete_run();
	end
endmodule
